/* hw/autoneg_np_consts.svh */
// Offsets, field positions and reset values of the auto-negotiation status registers
//
// Overview of operation
// - Partner acknowledge bit updated by hardware only
// - Code in bits 10:0, bit 13 message flag
// - Bit 12 shows partner can comply
// - Bit 11 is inverse of previous transmitted toggle
// - Code field read-only, resets to zero
// - Expansion bits 15:5 read zero, writes ignored
// - Bit 4 set on parallel detection fault
// - Bit 3 partner next page support, resets zero
// - Bit 2 reads one, fixed, read-only
// - Bit 1 set on page, cleared by read
// - Bit 0 partner autoneg support, resets zero
`ifndef AUTONEG_NP_CONSTS_SVH
`define AUTONEG_NP_CONSTS_SVH

// Register indices and their APB byte addresses (index times four)
`define PNPW_INDEX          8'h05
`define EXP_INDEX           8'h06
`define PNPW_ADDR           12'h014
`define EXP_ADDR            12'h018

// Received next-page word fields
`define PNPW_ACK_BIT        14
`define PNPW_MP_BIT         13
`define PNPW_PARTNER_CAN_COMPLY_BIT       12
`define PNPW_TOGGLE_BIT     11
`define PNPW_CODE_MSB       10
`define PNPW_CODE_LSB       0
`define PNPW_CODE_WIDTH     11
`define PNPW_CODE_RESET     11'h000

// Expansion register fields
`define EXP_PDF_BIT         4
`define EXP_LP_NP_BIT       3
`define EXP_NP_BIT          2
`define EXP_PAGE_RX_BIT     1
`define EXP_LP_AN_BIT       0
`define EXP_NP_RESET        1'h1
`define EXP_STATUS_RESET    1'h0

// Register width and bus data width
`define REG_WIDTH           16
`define BUS_WIDTH           32

`endif

/* hw/autoneg_np_pkg.sv */
// Types shared by the auto-negotiation status register files
package autoneg_np_pkg;

    // One 16-bit status register word
    typedef logic [15:0] reg_word_t;

    // Which register an APB address selects
    typedef enum logic [1:0] {
        SEL_NONE      = 2'b00,
        SEL_PARTNER   = 2'b01,
        SEL_EXPANSION = 2'b10
    } reg_sel_e;

endpackage : autoneg_np_pkg

/* hw/status_capture.sv */
// Loadable status register with clock enable and synchronous reset
`timescale 1ns/1ps
module status_capture #(
    parameter int              WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    // Holds value until loaded; frozen while clock enable is low
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            q <= RESET_VALUE;
        end else if (ce && load) begin
            q <= d;
        end
    end

endmodule : status_capture

/* hw/autoneg_next_page_status_regs.sv */
// Auto-negotiation received next-page word and expansion status registers on APB
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "autoneg_np_consts.svh"
module autoneg_next_page_status_regs
    import autoneg_np_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_sys,                    // System clock, 50 MHz
    input  wire logic              reset_n,                    // Synchronous reset, active low
    input  wire logic              ce,                         // Clock enable, freezes state
    // APB slave
    input  wire logic [ADDR_W-1:0] paddr,                      // Byte address
    input  wire logic              psel,                       // Slave select
    input  wire logic              penable,                    // Access phase
    input  wire logic              pwrite,                     // Write when high
    input  wire logic [31:0]       pwdata,                     // Write data, ignored
    input  wire logic [3:0]        pstrb,                      // Byte strobes, ignored
    output logic      [31:0]       prdata,                     // Read data
    output logic                   pready,                     // Transfer complete
    output logic                   pslverr,                    // Unmapped address
    // Negotiation engine side
    input  wire logic              page_rx_strobe,             // Link code word page received
    input  wire logic [15:0]       page_rx_word,               // Received link code word
    input  wire logic              last_tx_toggle,             // Toggle of last sent word
    input  wire logic              ack_update_strobe,          // Burst carried acknowledge
    input  wire logic              ack_update_value,           // Acknowledge from burst
    input  wire logic              parallel_detect_fault_in,   // Parallel detection fault
    input  wire logic              partner_next_page_capable_in, // Partner next page ability
    input  wire logic              partner_autoneg_capable_in, // Partner autoneg ability
    output logic                   page_received               // Unread page pending
);

    // ------------------------------------------------------------------
    // Stored fields of the received next-page word
    // ------------------------------------------------------------------
    logic                          partner_ack;                // Partner acknowledge
    logic                          next_partner_ack;           // Next acknowledge value
    logic                          message_page_flag;          // Message page flag
    logic                          partner_can_comply;         // Partner can comply
    logic                          rx_toggle;                  // Reported toggle
    logic [`PNPW_CODE_WIDTH-1:0]   rx_code;                    // Received code field
    logic [13:0]                   page_fields_d;              // Fields loaded on a page
    logic [13:0]                   page_fields_q;              // Fields as stored

    // ------------------------------------------------------------------
    // Expansion register state
    // ------------------------------------------------------------------
    logic                          parallel_detect_fault;      // Fault flag
    logic                          partner_next_page_capable;  // Partner next page ability
    logic                          partner_autoneg_capable;    // Partner autoneg ability
    logic                          local_next_page_capable;    // Fixed local ability
    logic                          page_rx_flag;               // Sticky page received
    logic                          next_page_rx_flag;          // Next sticky value

    // ------------------------------------------------------------------
    // Bus decode and read path
    // ------------------------------------------------------------------
    reg_sel_e                      sel;                        // Decoded register
    logic                          setup_phase;                // APB setup cycle
    logic                          access_done;                // Access completes this edge
    logic                          read_done;                  // Read completes this edge
    reg_word_t                     partner_word;               // Assembled partner word
    reg_word_t                     expansion_word;             // Assembled expansion word
    reg_word_t                     read_word;                  // Word for selected register
    logic                          read_err;                   // Unmapped access
    logic                          read_expansion;             // Setup targeted expansion
    logic                          read_expansion_q;           // Captured at setup
    logic                          page_seen_q;                // Flag value that was returned

    // Zero-wait slave; clock enable low holds the access phase
    assign pready      = ce;
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && ce;
    assign read_done   = access_done && !pwrite;

    // Address decode into register select
    always_comb begin
        if (paddr == ADDR_W'(`PNPW_ADDR)) begin
            sel = SEL_PARTNER;
        end else if (paddr == ADDR_W'(`EXP_ADDR)) begin
            sel = SEL_EXPANSION;
        end else begin
            sel = SEL_NONE;
        end
    end

    // ------------------------------------------------------------------
    // Received page capture
    // ------------------------------------------------------------------

    // Toggle reported is the inverse of the one last transmitted
    always_comb begin
        page_fields_d = '0;
        page_fields_d[`PNPW_MP_BIT] = page_rx_word[`PNPW_MP_BIT];
        page_fields_d[`PNPW_PARTNER_CAN_COMPLY_BIT] = page_rx_word[`PNPW_PARTNER_CAN_COMPLY_BIT];
        page_fields_d[`PNPW_TOGGLE_BIT] = ~last_tx_toggle;
        page_fields_d[`PNPW_CODE_MSB:`PNPW_CODE_LSB] =
            page_rx_word[`PNPW_CODE_MSB:`PNPW_CODE_LSB];
    end

    // Page fields only load from the engine, never from the bus
    status_capture #(
        .WIDTH       (14),
        .RESET_VALUE (14'h0000)
    ) u_page_fields (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .ce      (ce),
        .load    (page_rx_strobe),
        .d       (page_fields_d),
        .q       (page_fields_q)
    );

    // Split stored page into its named fields
    assign message_page_flag  = page_fields_q[`PNPW_MP_BIT];
    assign partner_can_comply = page_fields_q[`PNPW_PARTNER_CAN_COMPLY_BIT];
    assign rx_toggle          = page_fields_q[`PNPW_TOGGLE_BIT];
    assign rx_code            = page_fields_q[`PNPW_CODE_MSB:`PNPW_CODE_LSB];

    // Acknowledge follows incoming bursts; a page carries one too
    always_comb begin
        next_partner_ack = partner_ack;
        if (ack_update_strobe) begin
            next_partner_ack = ack_update_value;
        end else if (page_rx_strobe) begin
            next_partner_ack = page_rx_word[`PNPW_ACK_BIT];
        end
    end

    // Acknowledge register, hardware owned
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            partner_ack <= 1'b0;
        end else if (ce) begin
            partner_ack <= next_partner_ack;
        end
    end

    // ------------------------------------------------------------------
    // Expansion status
    // ------------------------------------------------------------------

    // Fault flag follows the parallel detection result
    status_capture #(
        .WIDTH       (1),
        .RESET_VALUE (`EXP_STATUS_RESET)
    ) u_pdf (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .ce      (ce),
        .load    (1'b1),
        .d       (parallel_detect_fault_in),
        .q       (parallel_detect_fault)
    );

    // Partner next page ability, zero after reset
    status_capture #(
        .WIDTH       (1),
        .RESET_VALUE (`EXP_STATUS_RESET)
    ) u_lp_np (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .ce      (ce),
        .load    (1'b1),
        .d       (partner_next_page_capable_in),
        .q       (partner_next_page_capable)
    );

    // Partner auto-negotiation ability, zero after reset
    status_capture #(
        .WIDTH       (1),
        .RESET_VALUE (`EXP_STATUS_RESET)
    ) u_lp_an (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .ce      (ce),
        .load    (1'b1),
        .d       (partner_autoneg_capable_in),
        .q       (partner_autoneg_capable)
    );

    // Local next page ability is a fixed one
    assign local_next_page_capable = `EXP_NP_RESET;

    // Sticky page flag; a new page beats the read clear
    always_comb begin
        next_page_rx_flag = page_rx_flag;
        if (read_done && read_expansion_q && page_seen_q) begin
            next_page_rx_flag = 1'b0;
        end
        if (page_rx_strobe) begin
            next_page_rx_flag = 1'b1;
        end
    end

    // Page received flag register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            page_rx_flag <= 1'b0;
        end else if (ce) begin
            page_rx_flag <= next_page_rx_flag;
        end
    end

    assign page_received = page_rx_flag;

    // ------------------------------------------------------------------
    // Register word assembly
    // ------------------------------------------------------------------

    // Partner word; bit 15 not carried, reads zero
    always_comb begin
        partner_word = '0;
        partner_word[`PNPW_ACK_BIT]    = partner_ack;
        partner_word[`PNPW_MP_BIT]     = message_page_flag;
        partner_word[`PNPW_PARTNER_CAN_COMPLY_BIT]   = partner_can_comply;
        partner_word[`PNPW_TOGGLE_BIT] = rx_toggle;
        partner_word[`PNPW_CODE_MSB:`PNPW_CODE_LSB] = rx_code;
    end

    // Expansion word; upper bits stay zero
    always_comb begin
        expansion_word = '0;
        expansion_word[`EXP_PDF_BIT]     = parallel_detect_fault;
        expansion_word[`EXP_LP_NP_BIT]   = partner_next_page_capable;
        expansion_word[`EXP_NP_BIT]      = local_next_page_capable;
        expansion_word[`EXP_PAGE_RX_BIT] = page_rx_flag;
        expansion_word[`EXP_LP_AN_BIT]   = partner_autoneg_capable;
    end

    // Select word for the addressed register
    always_comb begin
        read_word      = '0;
        read_err       = 1'b0;
        read_expansion = 1'b0;
        case (sel)
            SEL_PARTNER: begin
                read_word = partner_word;
            end
            SEL_EXPANSION: begin
                read_word      = expansion_word;
                read_expansion = !pwrite;
            end
            default: begin
                read_err = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // APB read data, captured in the setup cycle
    // ------------------------------------------------------------------

    // Read data and error are registered at setup, held through access
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (setup_phase) begin
                prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, read_word};
                pslverr <= read_err;
            end else if (access_done) begin
                pslverr <= 1'b0;
            end
        end
    end

    // Remember whether the page flag was returned by this read
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            read_expansion_q <= 1'b0;
            page_seen_q      <= 1'b0;
        end else if (ce) begin
            if (setup_phase) begin
                read_expansion_q <= read_expansion;
                page_seen_q      <= page_rx_flag;
            end else if (access_done) begin
                read_expansion_q <= 1'b0;
                page_seen_q      <= 1'b0;
            end
        end
    end

    // Write data and strobes have no destination; all bits read-only
    logic unused_write;
    assign unused_write = ^{pwdata, pstrb};

endmodule : autoneg_next_page_status_regs

/* tb/autoneg_np_properties.sv */
// Concurrent checks on the ports of the auto-negotiation status register block
`timescale 1ns/1ps
`include "autoneg_np_consts.svh"
module autoneg_np_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic              clk_sys,
    input wire logic              reset_n,
    input wire logic              ce,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              page_rx_strobe,
    input wire logic              parallel_detect_fault_in,
    input wire logic              partner_next_page_capable_in,
    input wire logic              partner_autoneg_capable_in,
    input wire logic              page_received
);
    // Completing transfers and the register they address
    wire acc     = psel && penable && ce;
    wire exp_rd  = acc && !pwrite && (paddr == `EXP_ADDR);
    wire pnpw_rd = acc && !pwrite && (paddr == `PNPW_ADDR);
    wire mapped  = (paddr == `EXP_ADDR) || (paddr == `PNPW_ADDR);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    AST_PAGE_SET: assert property (page_rx_strobe && ce |=> page_received)
        else $error("page flag not set after page strobe");
    AST_PAGE_CLR: assert property (exp_rd && prdata[1] && !page_rx_strobe |=> !page_received)
        else $error("page flag not cleared by read");
    AST_PAGE_HOLD: assert property (!page_rx_strobe && !exp_rd |=> $stable(page_received))
        else $error("page flag changed without cause");
    AST_EXP_UPPER: assert property (exp_rd |-> prdata[31:5] == 27'h0)
        else $error("expansion upper bits not zero");
    AST_EXP_NP: assert property (exp_rd |-> prdata[2])
        else $error("local next page bit not one");
    AST_EXP_STATUS: assert property (exp_rd && $past(ce) && $past(ce, 2)
        |-> {prdata[4], prdata[3], prdata[0]} == $past({parallel_detect_fault_in,
        partner_next_page_capable_in, partner_autoneg_capable_in}, 2))
        else $error("expansion status bits do not follow inputs");
    AST_WRITE_KEEP: assert property (acc && pwrite && page_received |=> page_received)
        else $error("write disturbed page flag");
    AST_MAPPED_OK: assert property (acc && mapped |-> !pslverr)
        else $error("error response on mapped register");
    AST_PNPW_UPPER: assert property (pnpw_rd |-> prdata[31:15] == 17'h0)
        else $error("partner word upper bits not zero");

    // Main scenarios
    COV_PAGE_CLR: cover property (exp_rd && prdata[1]);
    COV_WRITE: cover property (acc && pwrite && page_received);
    COV_FAULT: cover property (exp_rd && prdata[4]);
endmodule : autoneg_np_checker

bind autoneg_next_page_status_regs autoneg_np_checker #(.ADDR_W(ADDR_W)) i_autoneg_np_checker (
    .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
    .page_rx_strobe(page_rx_strobe), .parallel_detect_fault_in(parallel_detect_fault_in),
    .partner_next_page_capable_in(partner_next_page_capable_in),
    .partner_autoneg_capable_in(partner_autoneg_capable_in), .page_received(page_received));

/* tb/autoneg_next_page_status_regs_tb.sv */
// Self-checking bench for the auto-negotiation status register block
`timescale 1ns/1ps
`include "autoneg_np_consts.svh"
module autoneg_next_page_status_regs_tb;
    import autoneg_np_pkg::*;
    logic clk_sys = 1'h0, reset_n = 1'h0, ce = 1'h1;           // Clock, reset, enable
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;          // APB control
    logic [11:0] paddr = 12'h000;                              // APB address
    logic [31:0] pwdata = 32'h0, prdata;                       // APB data
    logic [3:0]  pstrb = 4'hF;                                 // APB strobes
    logic pready, pslverr, page_received;                      // Block outputs
    logic page_rx_strobe = 1'h0, last_tx_toggle = 1'h0;        // Page event
    logic [15:0] page_rx_word = 16'h0, w, pw_exp;              // Page word, expected word
    logic ack_update_strobe = 1'h0, ack_update_value = 1'h0;   // Acknowledge event
    logic flt = 1'h0, lpnp = 1'h0, lpan = 1'h0;                // Partner status levels
    int err_total = 0, samples_checked = 0;                    // Tallies

    autoneg_next_page_status_regs i_autoneg_next_page_status_regs (
        .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .page_rx_strobe(page_rx_strobe), .page_rx_word(page_rx_word),
        .last_tx_toggle(last_tx_toggle), .ack_update_strobe(ack_update_strobe),
        .ack_update_value(ack_update_value), .parallel_detect_fault_in(flt),
        .partner_next_page_capable_in(lpnp), .partner_autoneg_capable_in(lpan),
        .page_received(page_received));

    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    // Verdict and end of run
    task final_report;
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // Compare one 32-bit result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic [11:0] a, input logic wr_en, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= wr_en;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            chk(32'h0, 32'h1);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Read and compare data and error flag
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(a, 1'h0, 32'h0, q, e);
        chk(q, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask : rd

    // Write and compare error flag
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] q;
        logic e;
        apb(a, 1'h1, d, q, e);
        chk({31'h0, e}, {31'h0, xe});
    endtask : wr

    // One-cycle page and acknowledge events
    task automatic ev(input logic ps, input logic [15:0] wd, input logic t,
                      input logic as, input logic av);
        @(posedge clk_sys);
        page_rx_strobe <= ps;
        page_rx_word <= wd;
        last_tx_toggle <= t;
        ack_update_strobe <= as;
        ack_update_value <= av;
        @(posedge clk_sys);
        page_rx_strobe <= 1'h0;
        ack_update_strobe <= 1'h0;
    endtask : ev

    // Reset values of both registers
    task automatic t_reset;
        rd(`PNPW_ADDR, 32'h0000_0000, 1'h0);
        rd(`EXP_ADDR, 32'h0000_0004, 1'h0);
    endtask : t_reset

    // Page fields, inverted toggle and read-to-clear flag
    task automatic t_page;
        for (int i = 0; i < 4; i++) begin
            w = {1'h1, i[0], i[0], i[1], i[1], 11'h2A5 + 11'(i)};
            pw_exp = {1'h0, w[14:12], ~w[11], w[10:0]};
            ev(1'h1, w, w[11], 1'h0, 1'h0);
            rd(`PNPW_ADDR, {16'h0, pw_exp}, 1'h0);
            rd(`EXP_ADDR, 32'h0000_0006, 1'h0);
            rd(`EXP_ADDR, 32'h0000_0004, 1'h0);
        end
    endtask : t_page

    // Acknowledge strobe beats the page bit, writes change nothing
    task automatic t_ack_write;
        ev(1'h1, 16'h0000, 1'h0, 1'h1, 1'h1);
        rd(`PNPW_ADDR, 32'h0000_4800, 1'h0);
        ev(1'h0, 16'hFFFF, 1'h0, 1'h1, 1'h0);
        wr(`PNPW_ADDR, 32'hFFFF_FFFF, 1'h0);
        wr(`EXP_ADDR, 32'hFFFF_FFFF, 1'h0);
        rd(`PNPW_ADDR, 32'h0000_0800, 1'h0);
        rd(`EXP_ADDR, 32'h0000_0006, 1'h0);
        rd(`EXP_ADDR, 32'h0000_0004, 1'h0);
    endtask : t_ack_write

    // Every combination of the partner status levels
    task automatic t_status;
        for (int i = 0; i < 8; i++) begin
            flt <= i[2];
            lpnp <= i[1];
            lpan <= i[0];
            rd(`EXP_ADDR, {27'h0, i[2], i[1], 1'h1, 1'h0, i[0]}, 1'h0);
        end
    endtask : t_status

    // Unmapped addresses and frozen state with enable low
    task automatic t_misc;
        rd(12'h01C, 32'h0, 1'h1);
        wr(12'h000, 32'h1, 1'h1);
        @(posedge clk_sys);
        ce <= 1'h0;
        ev(1'h1, 16'h07FF, 1'h0, 1'h0, 1'h0);
        chk({31'h0, pready}, 32'h0);
        @(posedge clk_sys);
        ce <= 1'h1;
        chk({31'h0, page_received}, 32'h0);
        rd(`PNPW_ADDR, 32'h0000_0800, 1'h0);
    endtask : t_misc

    // Main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'h1;
        t_reset();
        t_page();
        t_ack_write();
        t_status();
        t_misc();
        final_report();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        final_report();
    end
endmodule : autoneg_next_page_status_regs_tb
